// [keypad_parameter_editor_tb_top.sv]
`timescale 1ns/1ps
module keypad_parameter_editor_tb_top
   import kpe_pkg::*;
;
   localparam int HOLD = 20;
   logic CLK_SYS, SYS_RST, SER_WR, NVM_WR, UNLOCKED, SER_REJECT;
   logic FAULT_MAIN, FAULT_NOW, FAULT_TOP;
   logic [KPE_NUM_KEYS-1:0] KEY_PIN;
   logic [6:0]  SER_NUM, NVM_ADDR;
   logic [19:0] SER_VALUE, NVM_WDATA, v;
   logic [15:0] FAULT_NUM, fc;
   logic [7:0]  STATUS_IN, STATUS_LED;
   kpe_disp_t   DISP_TOP, DISP_BOT;
   logic [6:0]  sn [20];
   logic [19:0] sv [20];
   int errors, total_checks, cycles, nwr, c0, n;
   bit ok;
   // ---------------------------------------------------------------
   // Clock, monitors, timeout
   // ---------------------------------------------------------------
   initial begin
      CLK_SYS = 1'b0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   // Count stored writes and cut a hang short
   always @(posedge CLK_SYS) begin
      if (NVM_WR === 1'b1) nwr++;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   kpe_keypad_model model_u (.CLK_SYS(CLK_SYS), .KEY_PIN(KEY_PIN));
   kpe_editor #(.SEQ_CYCLES(50), .UNLOCK_CYCLES(400),
      .HOLD_CYCLES(HOLD), .TENTH_CYCLES(5)) dut_u (
      .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .KEY_PIN(KEY_PIN),
      .SER_WR(SER_WR), .SER_NUM(SER_NUM), .SER_VALUE(SER_VALUE),
      .FAULT_NUM(FAULT_NUM), .NVM_RDATA(20'h0_0000),
      .STATUS_IN(STATUS_IN), .NVM_WR(NVM_WR), .NVM_ADDR(NVM_ADDR),
      .NVM_WDATA(NVM_WDATA), .DISP_TOP(DISP_TOP), .DISP_BOT(DISP_BOT),
      .STATUS_LED(STATUS_LED), .UNLOCKED(UNLOCKED),
      .SER_REJECT(SER_REJECT), .FAULT_MAIN(FAULT_MAIN),
      .FAULT_NOW(FAULT_NOW), .FAULT_TOP(FAULT_TOP));
   // ---------------------------------------------------------------
   // Expectations and helpers
   // ---------------------------------------------------------------
   function automatic logic [2:0] fclass(input logic [15:0] f);
      return {f == F_MAIN, f >= F_NOW_LO && f <= F_NOW_HI,
              f >= F_TOP_LO && f <= F_TOP_HI};
   endfunction
   // Step with clamping at both ends of the value field
   function automatic logic [19:0] stepv(input logic [19:0] x,
      input logic [19:0] d, input bit up);
      if (up) return (x > VAL_MAX - d) ? VAL_MAX : x + d;
      return (x < d) ? 20'h0_0000 : x - d;
   endfunction
   task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic key(input logic [4:0] k, input int h);
      model_u.press(k, h);
      #1;
   endtask
   task automatic sel(input logic [4:0] d, input int p);
      key(d, 2);
      key(5'(p / 10), 2);
      key(5'(p % 10), 2);
   endtask
   // Back-to-back serial writes, each answer checked a cycle later
   task automatic ser_burst(input int cnt);
      for (int i = 0; i <= cnt; i++) begin
         @(posedge CLK_SYS);
         SER_WR <= (i < cnt);
         SER_NUM <= sn[i % 20];
         SER_VALUE <= sv[i % 20];
         #1;
         if (i > 0) begin
            ok = sn[i-1] >= P_SER_FIRST && sn[i-1] <= P_SER_LAST;
            check("nvm_wr", ok, NVM_WR);
            check("ser_reject", !ok, SER_REJECT);
            if (ok) check("nvm_addr", sn[i-1], NVM_ADDR);
            if (ok) check("nvm_wdata", sv[i-1], NVM_WDATA);
         end
      end
   endtask
   task automatic ser_one(input logic [6:0] p, input logic [19:0] x);
      sn[0] = p;
      sv[0] = x;
      ser_burst(1);
      v = x;
      repeat (HOLD + 5) @(posedge CLK_SYS);
   endtask
   task automatic step(input logic [4:0] pre, input bit use_pre,
      input bit up, input logic [19:0] d);
      if (use_pre) key(pre, 2);
      key(up ? KEY_UP : KEY_DOWN, 2);
      v = stepv(v, d, up);
      check("disp_value", v, DISP_TOP.value);
      check("nvm_wdata", v, NVM_WDATA);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      SYS_RST = 1'b1;
      SER_WR = 1'b0;
      SER_NUM = 7'h00;
      SER_VALUE = 20'h0_0000;
      FAULT_NUM = 16'h0000;
      STATUS_IN = 8'h00;
      void'($urandom(32'h5e1e));
      repeat (8) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
      #1;
      check("top_num", 7'h01, DISP_TOP.num);
      check("points", 2'b10, {DISP_TOP.point, DISP_BOT.point});
      check("unlocked", 1'b0, UNLOCKED);
      $display("test reset done");
      // Fault codes around the main code, the upper end of the now range and across the top range, then random codes
      for (int i = 0; i < 24; i++) begin
         fc = (i < 12) ? 16'h0100 + 16'(i) : 16'($urandom_range(0, 1023));
         if (i >= 4 && i < 8) fc = 16'h0226 + 16'(i - 4);
         if (i >= 8 && i < 12) fc = 16'h0311 + 16'(i - 8) * 16'h0009;
         @(posedge CLK_SYS);
         FAULT_NUM <= fc;
         STATUS_IN <= 8'($urandom);
         @(posedge CLK_SYS);
         #1;
         check("fault_class", fclass(fc),
            {FAULT_MAIN, FAULT_NOW, FAULT_TOP});
         check("status_led", STATUS_IN, STATUS_LED);
      end
      $display("test faults done");
      foreach (sn[i]) begin
         sn[i] = 7'($urandom_range(0, 99));
         sv[i] = 20'($urandom_range(0, 999999));
      end
      sn[0] = 7'h1d;
      sn[1] = 7'h1e;
      sn[2] = 7'h2b;
      sn[3] = 7'h2c;
      ser_burst(20);
      $display("test serial done");
      ser_one(P_SER_FIRST + 7'h01, 20'h0_01f4);
      sel(KEY_TOP, 31);
      check("top_num", 7'h1f, DISP_TOP.num);
      check("top_value", v, DISP_TOP.value);
      key(KEY_BOT, 2);
      check("points", 2'b01, {DISP_TOP.point, DISP_BOT.point});
      check("top_kept", 7'h1f, DISP_TOP.num);
      key(KEY_TOP, 2);
      $display("test display done");
      step(KEY_STAR, 0, 1, STEP_ONE);
      step(KEY_STAR, 1, 1, STEP_TEN);
      step(KEY_STAR, 0, 1, STEP_TEN);
      repeat (HOLD + 5) @(posedge CLK_SYS);
      step(KEY_STAR, 0, 1, STEP_ONE);
      step(KEY_HASH, 1, 0, STEP_HUND);
      repeat (HOLD + 5) @(posedge CLK_SYS);
      step(KEY_HASH, 0, 0, STEP_ONE);
      ser_one(7'h1f, VAL_MAX);
      step(KEY_HASH, 0, 1, STEP_ONE);
      ser_one(7'h1f, 20'h0_0000);
      step(KEY_HASH, 0, 0, STEP_ONE);
      $display("test steps done");
      ser_one(7'h1f, 20'h0_03e8);
      c0 = nwr;
      key(KEY_UP, HOLD + 30);
      n = nwr - c0;
      check("repeat_count", 1'b1, n >= 5 && n <= 8);
      check("repeat_value", v + 20'(n), DISP_TOP.value);
      $display("test repeat done");
      sel(KEY_TOP, 5);
      c0 = nwr;
      key(KEY_UP, 2);
      key(KEY_DOWN, 2);
      check("ro_writes", c0, nwr);
      sel(KEY_TOP, 47);
      key(KEY_UP, 2);
      check("locked_writes", c0, nwr);
      sel(KEY_TOP, 45);
      key(KEY_UP, 2);
      check("free_writes", c0 + 1, nwr);
      check("free_addr", P_MINCH, NVM_ADDR);
      $display("test protect done");
      // Unlock, edit a protected value, relock, then disable the lock
      sel(KEY_TOP, 61);
      key(KEY_FN1, 2);
      key(KEY_FN2, 2);
      key(KEY_ENTER, 2);
      key(KEY_UP, 2);
      check("unlocked", 1'b1, UNLOCKED);
      sel(KEY_TOP, 60);
      c0 = nwr;
      key(KEY_UP, 2);
      check("unlocked_writes", c0 + 1, nwr);
      check("unlocked_value", 20'h0_0002, DISP_TOP.value);
      repeat (410) @(posedge CLK_SYS);
      #1;
      check("relocked", 1'b0, UNLOCKED);
      sel(KEY_TOP, 61);
      key(KEY_FN1, 2);
      key(KEY_FN2, 2);
      key(KEY_ENTER, 2);
      key(KEY_UP, 2);
      key(KEY_UP, 2);
      repeat (410) @(posedge CLK_SYS);
      #1;
      check("lock_disabled", 1'b1, UNLOCKED);
      $display("test unlock done");
      summarize();
   end
endmodule

// [kpe_editor.sv]
`timescale 1ns/1ps
module kpe_editor
   import kpe_pkg::*;
#(
   parameter longint SEQ_CYCLES    = SEQ_CYC,
   parameter longint UNLOCK_CYCLES = UNLOCK_CYC,
   parameter longint HOLD_CYCLES   = HOLD_CYC,
   parameter longint TENTH_CYCLES  = TENTH_CYC
) (
   input  wire logic                      CLK_SYS,
   input  wire logic                      SYS_RST,
   input  wire logic [KPE_NUM_KEYS-1:0]   KEY_PIN,
   input  wire logic                      SER_WR,
   input  wire logic [6:0]                SER_NUM,
   input  wire logic [19:0]               SER_VALUE,
   input  wire logic [15:0]               FAULT_NUM,
   input  wire logic [19:0]               NVM_RDATA,
   input  wire logic [KPE_NUM_LEDS-1:0]   STATUS_IN,
   output logic                           NVM_WR,
   output logic [6:0]                     NVM_ADDR,
   output logic [19:0]                    NVM_WDATA,
   output kpe_disp_t                      DISP_TOP,
   output kpe_disp_t                      DISP_BOT,
   output logic [KPE_NUM_LEDS-1:0]        STATUS_LED,
   output logic                           UNLOCKED,
   output logic                           SER_REJECT,
   output logic                           FAULT_MAIN,
   output logic                           FAULT_NOW,
   output logic                           FAULT_TOP
);
   // ---------------------------------------------------------------
   // Key input synchroniser
   // ---------------------------------------------------------------
   logic [KPE_NUM_KEYS-1:0] s1, s2, s3, keys;
   logic [KPE_NUM_KEYS-1:0] keys_q;
   // Three stages, accept when last two agree
   always_ff @(posedge CLK_SYS) begin
      s1 <= KEY_PIN;
      s2 <= s1;
      s3 <= s2;
   end
   genvar g;
   generate
      for (g = 0; g < KPE_NUM_KEYS; g++) begin : g_key
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST) begin
               keys[g] <= 1'b0;
            end else if (s2[g] == s3[g]) begin
               keys[g] <= s3[g];
            end
         end
      end
   endgenerate
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         keys_q <= '0;
      end else begin
         keys_q <= keys;
      end
   end
   wire [KPE_NUM_KEYS-1:0] press = keys & ~keys_q;
   // Lowest pressed key wins the code
   logic [4:0] press_code;
   logic       press_any;
   always_comb begin
      press_code = 5'h00;
      press_any  = 1'b0;
      for (int i = KPE_NUM_KEYS - 1; i >= 0; i--) begin
         if (press[i]) begin
            press_code = 5'(i);
            press_any  = 1'b1;
         end
      end
   end
   wire is_digit = press_any && (press_code <= 5'h09);
   wire up_held  = keys[KEY_UP];
   wire dn_held  = keys[KEY_DOWN];
   wire arr_held = up_held | dn_held;
   wire arr_press = press[KEY_UP] | press[KEY_DOWN];
   // ---------------------------------------------------------------
   // Parameter store
   // ---------------------------------------------------------------
   logic [19:0] params [KPE_NUM_PARAMS];
   logic        sel_bot;
   logic [6:0]  num_top, num_bot;
   wire  [6:0]  act_num = sel_bot ? num_bot : num_top;
   wire  [19:0] act_val = params[act_num];
   // ---------------------------------------------------------------
   // Lock handling
   // ---------------------------------------------------------------
   kpe_seq_t    seq;
   logic [31:0] seq_cnt;
   logic [39:0] unl_cnt;
   logic        unlocked;
   wire lock_lock_disable_option = (params[P_LOCK_OPT] == OPT_LOCK_DISABLE_OPTION);
   wire is_free = (act_num >= P_SER_FIRST && act_num <= P_FREE_LAST) ||
                  act_num == P_MINCH || act_num == P_INCH;
   wire is_ro = (act_num <= P_RO_LAST);
   // Lock option editable once the sequence is armed
   wire arm_opt  = (seq == KPE_SEQ_ARM) && (act_num == P_LOCK_OPT);
   wire may_edit = !is_ro && (is_free || unlocked || lock_lock_disable_option || arm_opt);
   wire seq_tmo  = (seq_cnt >= 32'(SEQ_CYCLES));
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         seq     <= KPE_SEQ_IDLE;
         seq_cnt <= '0;
      end else if (press_any) begin
         seq_cnt <= '0;
         case (seq)
            KPE_SEQ_IDLE: seq <= (press_code == KEY_FN1) ? KPE_SEQ_FN1
                                                          : KPE_SEQ_IDLE;
            KPE_SEQ_FN1:  seq <= (press_code == KEY_FN2) ? KPE_SEQ_FN2
                                                          : KPE_SEQ_IDLE;
            KPE_SEQ_FN2:  seq <= (press_code == KEY_ENTER) ? KPE_SEQ_ARM
                                                            : KPE_SEQ_IDLE;
            KPE_SEQ_ARM:  seq <= (arr_press) ? KPE_SEQ_ARM : KPE_SEQ_IDLE;
            default:      seq <= KPE_SEQ_IDLE;
         endcase
      end else if (seq != KPE_SEQ_IDLE && seq != KPE_SEQ_ARM && seq_tmo) begin
         seq <= KPE_SEQ_IDLE;
      end else begin
         seq_cnt <= seq_tmo ? seq_cnt : seq_cnt + 32'h0000_0001;
      end
   end
   // ---------------------------------------------------------------
   // Step size and auto-repeat
   // ---------------------------------------------------------------
   logic [1:0]  step_mode; // 0 one, 1 ten, 2 hundred
   logic [31:0] hold_cnt, rel_cnt, rep_cnt;
   logic        rep_on;
   wire [31:0] upd_tenths = 32'(params[P_UPD_TIME]);
   wire [31:0] rep_limit  = upd_tenths * 32'(TENTH_CYCLES);
   wire rep_tick = rep_on && arr_held && (rep_cnt >= rep_limit - 32'h0000_0001);
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !arr_held) begin
         hold_cnt <= '0;
         rep_on   <= 1'b0;
         rep_cnt  <= '0;
      end else if (!rep_on) begin
         hold_cnt <= hold_cnt + 32'h0000_0001;
         rep_on   <= (hold_cnt >= 32'(HOLD_CYCLES));
      end else begin
         rep_cnt <= rep_tick ? 32'h0000_0000 : rep_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || arr_held) begin
         rel_cnt <= '0;
      end else if (rel_cnt <= 32'(HOLD_CYCLES)) begin
         rel_cnt <= rel_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         step_mode <= 2'd0;
      end else if (press[KEY_STAR]) begin
         step_mode <= 2'd1;
      end else if (press[KEY_HASH]) begin
         step_mode <= 2'd2;
      end else if (!arr_held && rel_cnt == 32'(HOLD_CYCLES)) begin
         step_mode <= 2'd0;
      end
   end
   wire [19:0] step = (step_mode == 2'd2) ? STEP_HUND :
                      (step_mode == 2'd1) ? STEP_TEN : STEP_ONE;
   // ---------------------------------------------------------------
   // Limits and new value
   // ---------------------------------------------------------------
   // Range per parameter
   wire in_rate = act_num == P_INCH_ACC ||
                  (act_num >= P_ACC_FIRST && act_num <= P_ACC_LAST) ||
                  (act_num >= P_DEC_FIRST && act_num <= P_DEC_LAST);
   wire in_delta = (act_num >= P_ADEL_FIRST && act_num <= P_ADEL_LAST) ||
                   (act_num >= P_DDEL_FIRST && act_num <= P_DDEL_LAST);
   wire in_upd = (act_num == P_UPD_TIME);
   wire [19:0] lim_lo = (in_rate || in_delta) ? RATE_MIN :
                        in_upd ? UPD_MIN : 20'h0_0000;
   wire [19:0] lim_hi = in_rate ? RATE_MAX : in_delta ? DELTA_MAX :
                        (act_num == P_RAMP_INIT) ? RAMP_MAX :
                        in_upd ? UPD_MAX :
                        (act_num == P_LOCK_OPT) ? OPT_LOCK_DISABLE_OPTION : VAL_MAX;
   wire [20:0] sum  = {1'b0, act_val} + {1'b0, step};
   wire [19:0] up_v = (sum > {1'b0, lim_hi}) ? lim_hi : sum[19:0];
   wire [19:0] dn_v = (act_val < lim_lo + step) ? lim_lo : act_val - step;
   wire do_up = (press[KEY_UP] || (rep_tick && up_held));
   wire do_dn = (press[KEY_DOWN] || (rep_tick && dn_held));
   wire kp_wr = (do_up ^ do_dn) && may_edit;
   wire [19:0] kp_val = do_up ? up_v : dn_v;
   wire ser_ok = SER_WR && SER_NUM >= P_SER_FIRST && SER_NUM <= P_SER_LAST;
   // Serial wins a same-cycle clash, the keypad write is dropped
   kpe_wr_t wr;
   assign wr.num   = ser_ok ? SER_NUM : act_num;
   assign wr.value = ser_ok ? SER_VALUE : kp_val;
   wire do_wr = ser_ok || kp_wr;
   always_ff @(posedge CLK_SYS) begin
      if (do_wr) begin
         params[wr.num] <= wr.value;
      end else if (SYS_RST) begin
         params[P_UPD_TIME] <= UPD_MIN;
         params[P_LOCK_OPT] <= '0; // Start locked, never unknown
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         NVM_WR    <= 1'b0;
         NVM_ADDR  <= '0;
         NVM_WDATA <= '0;
         SER_REJECT <= 1'b0;
      end else begin
         NVM_WR     <= do_wr;
         SER_REJECT <= SER_WR && !ser_ok;
         // Address and data hold the last stored write
         if (do_wr) begin
            NVM_ADDR  <= wr.num;
            NVM_WDATA <= wr.value;
         end
      end
   end
   wire unl_req = seq == KPE_SEQ_ARM && act_num == P_LOCK_OPT &&
                  kp_wr && kp_val == OPT_UNLOCK;
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         unlocked <= 1'b0;
         unl_cnt  <= '0;
      end else if (unl_req) begin
         unlocked <= 1'b1;
         unl_cnt  <= '0;
      end else if (unlocked) begin
         unl_cnt  <= unl_cnt + 40'h00_0000_0001;
         unlocked <= (unl_cnt < 40'(UNLOCK_CYCLES) - 40'h00_0000_0001);
      end
   end
   // ---------------------------------------------------------------
   // Display selection and entry
   // ---------------------------------------------------------------
   wire [6:0] dig_num = 7'(((act_num % 7'd10) * 7'd10) + 7'(press_code));
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         sel_bot <= 1'b0;
         num_top <= 7'h01;
         num_bot <= 7'h02;
      end else if (press[KEY_TOP]) begin
         sel_bot <= 1'b0;
      end else if (press[KEY_BOT]) begin
         sel_bot <= 1'b1;
      end else if (is_digit && !sel_bot) begin
         num_top <= dig_num;
      end else if (is_digit) begin
         num_bot <= dig_num;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         DISP_TOP   <= '0;
         DISP_BOT   <= '0;
         STATUS_LED <= '0;
         UNLOCKED   <= 1'b0;
      end else begin
         DISP_TOP   <= '{num_top, params[num_top], !sel_bot};
         DISP_BOT   <= '{num_bot, params[num_bot], sel_bot};
         STATUS_LED <= STATUS_IN;
         UNLOCKED   <= unlocked || lock_lock_disable_option;
      end
   end
   // ---------------------------------------------------------------
   // Fault classes
   // ---------------------------------------------------------------
   // Fault decode
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         FAULT_MAIN <= 1'b0;
         FAULT_NOW  <= 1'b0;
         FAULT_TOP  <= 1'b0;
      end else begin
         FAULT_MAIN <= FAULT_NUM == F_MAIN;
         FAULT_NOW  <= FAULT_NUM >= F_NOW_LO && FAULT_NUM <= F_NOW_HI;
         FAULT_TOP  <= FAULT_NUM >= F_TOP_LO && FAULT_NUM <= F_TOP_HI;
      end
   end
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_FAULT_MAIN: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      FAULT_NUM == F_MAIN |=> FAULT_MAIN && !FAULT_NOW)
      else $error("Main fault not classified");
   AST_NVM_FWD: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      ser_ok |=> NVM_WR && NVM_ADDR == $past(SER_NUM))
      else $error("Serial write not stored");
   AST_RO: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      act_num <= P_RO_LAST |-> !kp_wr)
      else $error("Display-only value edited");
   AST_SER_RANGE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      SER_WR && (SER_NUM < P_SER_FIRST || SER_NUM > P_SER_LAST)
      |=> SER_REJECT && (!NVM_WR || $past(kp_wr)))
      else $error("Serial out of range accepted");
   AST_RATE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      kp_wr && in_rate |-> kp_val >= RATE_MIN && kp_val <= RATE_MAX)
      else $error("Rate out of range");
   AST_DELTA: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      kp_wr && in_delta |-> kp_val <= DELTA_MAX && kp_val >= RATE_MIN)
      else $error("Delta out of range");
   AST_RAMP: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      kp_wr && act_num == P_RAMP_INIT |-> kp_val <= RAMP_MAX)
      else $error("Ramp start out of range");
   AST_LOCK: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      kp_wr && !is_free && !lock_lock_disable_option && !arm_opt |-> unlocked)
      else $error("Protected value edited while locked");
   AST_POINTS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      press[KEY_BOT] ##1 1 |=> DISP_BOT.point && !DISP_TOP.point)
      else $error("Active points wrong");
endmodule

// [kpe_keypad_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Operator keypad: raw key levels, one key at a time
// ---------------------------------------------------------------
module kpe_keypad_model
   import kpe_pkg::*;
(
   input  wire logic                  CLK_SYS,
   output logic [KPE_NUM_KEYS-1:0]    KEY_PIN
);
   // All keys released at start
   initial KEY_PIN = '0;
   // Press one key for hold cycles, then leave time to settle
   // Twenty key lines
   task automatic press(input logic [4:0] k, input int hold);
      @(posedge CLK_SYS);
      KEY_PIN[k] <= 1'b1;
      repeat (hold) @(posedge CLK_SYS);
      KEY_PIN[k] <= 1'b0;
      repeat (8) @(posedge CLK_SYS);
   endtask
endmodule

// [kpe_pkg.sv]
package kpe_pkg;
   // ---------------------------------------------------------------
   // Key codes and geometry
   // ---------------------------------------------------------------
   localparam int KPE_NUM_KEYS   = 20;
   localparam int KPE_NUM_LEDS   = 8;
   localparam int KPE_NUM_DIGITS = 8;
   localparam int KPE_PNUM_DIG   = 2;
   localparam int KPE_VAL_DIG    = 6;
   localparam int KPE_NUM_PARAMS = 100;
   localparam logic [4:0] KEY_DIG0   = 5'h00; // Digits 0..9 are codes 0..9
   localparam logic [4:0] KEY_TOP    = 5'h0a;
   localparam logic [4:0] KEY_BOT    = 5'h0b;
   localparam logic [4:0] KEY_UP     = 5'h0c;
   localparam logic [4:0] KEY_DOWN   = 5'h0d;
   localparam logic [4:0] KEY_STAR   = 5'h0e;
   localparam logic [4:0] KEY_HASH   = 5'h0f;
   localparam logic [4:0] KEY_FN1    = 5'h10;
   localparam logic [4:0] KEY_FN2    = 5'h11;
   localparam logic [4:0] KEY_ENTER  = 5'h12;
   localparam logic [4:0] KEY_CLEAR  = 5'h13;
   // ---------------------------------------------------------------
   // Parameter classes
   // ---------------------------------------------------------------
   localparam logic [6:0] P_RO_LAST    = 7'h19; // 25
   localparam logic [6:0] P_SER_FIRST  = 7'h1e; // 30
   localparam logic [6:0] P_SER_LAST   = 7'h2b; // 43
   localparam logic [6:0] P_FREE_LAST  = 7'h29; // 41
   localparam logic [6:0] P_MINCH      = 7'h2d; // 45
   localparam logic [6:0] P_INCH       = 7'h2e; // 46
   localparam logic [6:0] P_INCH_ACC   = 7'h2f; // 47
   localparam logic [6:0] P_RAMP_INIT  = 7'h30; // 48
   localparam logic [6:0] P_ACC_FIRST  = 7'h31; // 49
   localparam logic [6:0] P_ACC_LAST   = 7'h34; // 52
   localparam logic [6:0] P_ADEL_FIRST = 7'h35; // 53
   localparam logic [6:0] P_ADEL_LAST  = 7'h36; // 54
   localparam logic [6:0] P_DEC_FIRST  = 7'h37; // 55
   localparam logic [6:0] P_DEC_LAST   = 7'h39; // 57
   localparam logic [6:0] P_DDEL_FIRST = 7'h3a; // 58
   localparam logic [6:0] P_DDEL_LAST  = 7'h3b; // 59
   localparam logic [6:0] P_UPD_TIME   = 7'h3c; // Update time, tenths of s
   localparam logic [6:0] P_LOCK_OPT   = 7'h3d; // 0 lock,1 unlock,2 disable
   localparam logic [19:0] RATE_MIN  = 20'h0_0001;
   localparam logic [19:0] RATE_MAX  = 20'h0_0064; // 100
   localparam logic [19:0] DELTA_MAX = 20'h0_0005;
   localparam logic [19:0] RAMP_MAX  = 20'h0_0003;
   localparam logic [19:0] VAL_MAX   = 20'hf_423f; // 999999
   localparam logic [19:0] UPD_MIN   = 20'h0_0001;
   localparam logic [19:0] UPD_MAX   = 20'h0_0005;
   localparam logic [19:0] STEP_ONE  = 20'h0_0001;
   localparam logic [19:0] STEP_TEN  = 20'h0_000a;
   localparam logic [19:0] STEP_HUND = 20'h0_0064;
   localparam logic [19:0] OPT_UNLOCK = 20'h0_0001;
   localparam logic [19:0] OPT_LOCK_DISABLE_OPTION   = 20'h0_0002;
   // ---------------------------------------------------------------
   // Fault classes
   // ---------------------------------------------------------------
   localparam logic [15:0] F_MAIN      = 16'h0101;
   localparam logic [15:0] F_NOW_LO    = 16'h0202;
   localparam logic [15:0] F_NOW_HI    = 16'h0228;
   localparam logic [15:0] F_TOP_LO    = 16'h0313;
   localparam logic [15:0] F_TOP_HI    = 16'h0329;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam longint CLK_HZ      = 125_000_000;
   localparam longint SEQ_MS      = 5000;
   localparam longint UNLOCK_MIN  = 15;
   localparam longint HOLD_MS     = 1000;
   localparam longint TENTH_MS    = 100;
   localparam longint SEQ_CYC     = CLK_HZ / 1000 * SEQ_MS;
   localparam longint UNLOCK_CYC  = CLK_HZ * 60 * UNLOCK_MIN;
   localparam longint HOLD_CYC    = CLK_HZ / 1000 * HOLD_MS;
   localparam longint TENTH_CYC   = CLK_HZ / 1000 * TENTH_MS;
   typedef enum logic [1:0] {
      KPE_SEQ_IDLE = 2'b00,
      KPE_SEQ_FN1  = 2'b01,
      KPE_SEQ_FN2  = 2'b11,
      KPE_SEQ_ARM  = 2'b10
   } kpe_seq_t;
   typedef struct packed {
      logic [6:0]  num;
      logic [19:0] value;
   } kpe_wr_t;
   typedef struct packed {
      logic [6:0]  num;
      logic [19:0] value;
      logic        point;
   } kpe_disp_t;
endpackage
